// ---- wake_consts.svh ----
// register offsets, field positions and timing counts for the wake event block
`ifndef WAKE_CONSTS_SVH
`define WAKE_CONSTS_SVH
`define INT_STATUS_ADDR   8'h7C
`define INT_MASK_ADDR     8'h7D
`define WAKE_MASK_ADDR    8'h7E
`define WAKE_STATUS_ADDR  8'h7F
`define ENERGY_TIME_ADDR  8'h80
`define MAC_ADDR_BASE     8'h81
`define WAKE_BIT_ENERGY   0
`define WAKE_BIT_LINK     1
`define WAKE_BIT_PACKET   2
`define PME_STATUS_BIT    4
`define SYNC_BYTE         8'hFF
`define SYNC_LEN          6
`define ADDR_REPEATS      16
`define MAC_BYTES         6
`define ENERGY_TIME_RST   16'h00FF
`define NUM_PORTS         4
`endif

// ---- wake_event_detect_and_irq.sv ----
// wake event detection, status/mask registers and interrupt outputs
// What this block does
// - energy event only after programmed hold time
// - link wake event on link going up
// - sync is six consecutive 0xFF bytes
// - then sixteen unbroken copies of node address
// - sequence may sit at any payload offset
// - packet scan only with wake mask bit2
// - scan own-address and broadcast frames alike
// - incomplete sequence gives no wake action
// - valid wake packet asserts event line
// - enabled status bits 3:0 assert low interrupt
// - mask bits 3:0 gate interrupt conditions
// - status bits 3:0 record interrupt conditions
// - reading status clears bits 3:0
// - mask bit4 gates event line; status bit4
// - reading status clears bit 4
// - host reaches all registers through serial client
// - phy management port never sees these registers
// - per-port wake status bits 0,1,2 record events
`timescale 1ns/1ps
`include "wake_consts.svh"
module wake_event_detect_and_irq
  import wake_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // register port of the serial client, same clock domain
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  // port wake select for the per-port wake registers
  input  wire logic [1:0]  port_sel_i,
  // raw pins from the phys, asynchronous
  input  wire logic [3:0]  energy_pin_i,
  input  wire logic [3:0]  link_up_pin_i,
  // received frame stream, one port at a time, core clock
  input  wire logic [1:0]  rx_port_i,
  input  wire logic        rx_sof_i,
  input  wire logic        rx_vld_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_eof_i,
  input  wire logic        rx_to_node_i,
  input  wire logic        rx_bcast_i,
  // four interrupt conditions from elsewhere in the switch
  input  wire logic [3:0]  int_cond_i,
  output logic             int_line_low_o,
  output logic             wake_event_line_low_o
);
  logic [3:0]  energy_s1_q;
  logic [3:0]  energy_s2_q;
  logic [3:0]  link_s1_q;
  logic [3:0]  link_s2_q;
  logic [3:0]  link_prev_q;
  logic [15:0] energy_cnt_q [`NUM_PORTS];
  logic [3:0]  energy_fired_q;
  logic [15:0] energy_time_q;
  logic [47:0] mac_q;
  logic [2:0]  wake_mask_q [`NUM_PORTS];
  logic [2:0]  wake_stat_q [`NUM_PORTS];
  logic [4:0]  int_stat_q;
  logic [4:0]  int_mask_q;
  logic [7:0]  rdata_q;
  logic        int_low_q;
  logic        pme_low_q;
  logic [3:0]  energy_ev;
  logic [3:0]  link_ev;
  logic [3:0]  pkt_ev;
  logic        pkt_match;
  logic        scan_en;
  logic        frame_ok;
  logic        any_port_wake;
  logic        rd_int_stat;
  logic        rd_wake_stat;
  logic        wr_int_mask;
  logic        wr_wake_mask;
  logic        wr_energy_time;
  logic [7:0]  rdata_d;
  logic [2:0]  mac_idx;
  logic        wr_mac;

  // two-stage synchronisers on the phy level pins
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      energy_s1_q <= 4'h0;
      energy_s2_q <= 4'h0;
      link_s1_q   <= 4'h0;
      link_s2_q   <= 4'h0;
      link_prev_q <= 4'h0;
    end else begin
      energy_s1_q <= energy_pin_i;
      energy_s2_q <= energy_s1_q;
      link_s1_q   <= link_up_pin_i;
      link_s2_q   <= link_s1_q;
      link_prev_q <= link_s2_q;
    end
  end

  // link wake on rising edge of the synchronised link level
  assign link_ev = link_s2_q & ~link_prev_q;

  // energy must persist beyond the programmed count; one event per burst
  genvar p;
  generate
    for (p = 0; p < `NUM_PORTS; p++) begin : g_energy
      assign energy_ev[p] = energy_s2_q[p] && !energy_fired_q[p]
                            && energy_cnt_q[p] > energy_time_q;
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          energy_cnt_q[p]   <= 16'h0000;
          energy_fired_q[p] <= 1'b0;
        end else if (!energy_s2_q[p]) begin
          energy_cnt_q[p]   <= 16'h0000;
          energy_fired_q[p] <= 1'b0;
        end else begin
          if (energy_cnt_q[p] != 16'hFFFF) begin
            energy_cnt_q[p] <= energy_cnt_q[p] + 16'h0001;
          end
          if (energy_ev[p]) begin
            energy_fired_q[p] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // scan only frames for this node or broadcast, with the packet enable set
  assign frame_ok = rx_to_node_i || rx_bcast_i;
  assign scan_en  = wake_mask_q[rx_port_i][`WAKE_BIT_PACKET] && frame_ok;

  // one scanner shared by all ports; the stream carries one frame at a time
  wake_scanner u_scanner (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .enable_i   (scan_en),
    .sof_i      (rx_sof_i),
    .byte_vld_i (rx_vld_i),
    .byte_i     (rx_byte_i),
    .eof_i      (rx_eof_i),
    .mac_i      (mac_q),
    .match_o    (pkt_match)
  );

  assign pkt_ev = pkt_match ? 4'(4'h1 << rx_port_i) : 4'h0;

  // register decode; only the serial client reaches these, never the phy port
  assign rd_int_stat    = reg_rd_i && reg_addr_i == `INT_STATUS_ADDR;
  assign rd_wake_stat   = reg_rd_i && reg_addr_i == `WAKE_STATUS_ADDR;
  assign wr_int_mask    = reg_wr_i && reg_addr_i == `INT_MASK_ADDR;
  assign wr_wake_mask   = reg_wr_i && reg_addr_i == `WAKE_MASK_ADDR;
  assign wr_energy_time = reg_wr_i && reg_addr_i == `ENERGY_TIME_ADDR;
  assign wr_mac         = reg_wr_i && reg_addr_i >= `MAC_ADDR_BASE
                          && reg_addr_i < 8'(`MAC_ADDR_BASE + `MAC_BYTES);
  assign mac_idx        = 3'(reg_addr_i - `MAC_ADDR_BASE);

  // per-port wake status, sticky; a new event beats a read clear
  generate
    for (p = 0; p < `NUM_PORTS; p++) begin : g_wake
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          wake_stat_q[p] <= 3'h0;
          wake_mask_q[p] <= 3'h0;
        end else begin
          if (wr_wake_mask && port_sel_i == 2'(p)) begin
            wake_mask_q[p] <= reg_wdata_i[2:0];
          end
          wake_stat_q[p] <= ((rd_wake_stat && port_sel_i == 2'(p)) ? 3'h0 : wake_stat_q[p])
                            | {pkt_ev[p], link_ev[p], energy_ev[p]};
        end
      end
    end
  endgenerate

  // any enabled port wake event raises status bit 4
  always_comb begin
    any_port_wake = 1'b0;
    for (int i = 0; i < `NUM_PORTS; i++) begin
      any_port_wake = any_port_wake
                      | (|(wake_mask_q[i] & {pkt_ev[i], link_ev[i], energy_ev[i]}));
    end
  end

  // configuration registers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_mask_q    <= 5'h00;
      energy_time_q <= `ENERGY_TIME_RST;
      mac_q         <= 48'h0000_0000_0000;
    end else begin
      if (wr_int_mask) begin
        int_mask_q <= reg_wdata_i[4:0];
      end
      if (wr_energy_time) begin
        energy_time_q <= {8'h00, reg_wdata_i};
      end
      if (wr_mac) begin
        mac_q[8'(47 - 8 * mac_idx) -: 8] <= reg_wdata_i;
      end
    end
  end

  // status clears on read, set wins over a simultaneous clear
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_stat_q <= 5'h00;
    end else begin
      int_stat_q <= (rd_int_stat ? 5'h00 : int_stat_q)
                    | {any_port_wake, int_cond_i};
    end
  end

  // read mux, registered so data lands the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr_i == `INT_STATUS_ADDR) begin
      rdata_d = {3'h0, int_stat_q};
    end else if (reg_addr_i == `INT_MASK_ADDR) begin
      rdata_d = {3'h0, int_mask_q};
    end else if (reg_addr_i == `WAKE_MASK_ADDR) begin
      rdata_d = {5'h00, wake_mask_q[port_sel_i]};
    end else if (reg_addr_i == `WAKE_STATUS_ADDR) begin
      rdata_d = {5'h00, wake_stat_q[port_sel_i]};
    end else if (reg_addr_i == `ENERGY_TIME_ADDR) begin
      rdata_d = energy_time_q[7:0];
    end else if (reg_addr_i >= `MAC_ADDR_BASE
                 && reg_addr_i < 8'(`MAC_ADDR_BASE + `MAC_BYTES)) begin
      rdata_d = mac_q[8'(47 - 8 * mac_idx) -: 8];
    end
  end

  // outputs registered to keep the pins glitch free
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q   <= 8'h00;
      int_low_q <= 1'b1;
      pme_low_q <= 1'b1;
    end else begin
      if (reg_rd_i) begin
        rdata_q <= rdata_d;
      end
      int_low_q <= ~|(int_stat_q[3:0] & int_mask_q[3:0]);
      pme_low_q <= ~(int_stat_q[`PME_STATUS_BIT] & int_mask_q[`PME_STATUS_BIT]);
    end
  end

  assign reg_rdata_o           = rdata_q;
  assign int_line_low_o        = int_low_q;
  assign wake_event_line_low_o = pme_low_q;
endmodule

// ---- wake_event_detect_and_irq_props.sv ----
// checker for the wake event block, port-level relations only
`timescale 1ns/1ps
module wake_event_detect_and_irq_props (
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [3:0] energy_pin_i,
  input wire logic [3:0] link_up_pin_i,
  input wire logic       rx_eof_i,
  input wire logic [3:0] int_cond_i,
  input wire logic       int_line_low_o,
  input wire logic       wake_event_line_low_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] mask_q;
  logic       known_q;
  logic [2:0] quiet_q;
  logic [7:0] pins_q;
  wire        rd_st   = reg_rd_i && reg_addr_i == 8'h7C;
  // pins quiet this long means no pin event can still be in flight
  wire        moved   = pins_q != {energy_pin_i, link_up_pin_i};
  wire  [2:0] quiet_d = moved ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
  // mask mirror; reset value unknown, so trusted only after a write
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_q  <= 8'h00;
      known_q <= 1'b0;
      quiet_q <= 3'h0;
      pins_q  <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == 8'h7D) begin
        mask_q  <= reg_wdata_i;
        known_q <= 1'b1;
      end
      quiet_q <= quiet_d;
      pins_q  <= {energy_pin_i, link_up_pin_i};
    end
  end
  property p_unmapped;
    reg_rd_i && (reg_addr_i < 8'h7C || reg_addr_i > 8'h86) |=> reg_rdata_o == 8'h00;
  endproperty
  property p_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  // a mask write in the same cycle is already in force when the line is computed
  property p_int_set;
    known_q && (int_cond_i & ((reg_wr_i && reg_addr_i == 8'h7D) ? reg_wdata_i[3:0]
                                                                 : mask_q[3:0])) != 4'h0
      |-> ##2 !int_line_low_o;
  endproperty
  property p_int_mask;
    known_q && $past(known_q) && mask_q[3:0] == 4'h0 && $past(mask_q[3:0]) == 4'h0
      |-> int_line_low_o;
  endproperty
  property p_int_clr;
    rd_st && int_cond_i == 4'h0 ##1 int_cond_i == 4'h0 |-> ##1 int_line_low_o;
  endproperty
  property p_rd_zero;
    rd_st && int_cond_i == 4'h0 ##1 int_cond_i == 4'h0 ##1 rd_st && int_cond_i == 4'h0
      |=> reg_rdata_o[3:0] == 4'h0;
  endproperty
  property p_pme_mask;
    known_q && !mask_q[4] && !$past(mask_q[4]) |-> wake_event_line_low_o;
  endproperty
  property p_pme_clr;
    rd_st && quiet_q == 3'h7 && energy_pin_i == 4'h0 && !rx_eof_i
      |-> ##2 wake_event_line_low_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved without read");
  a_int_set: assert property (p_int_set) else $error("interrupt line not low");
  a_int_mask: assert property (p_int_mask) else $error("masked interrupt seen");
  a_int_clr: assert property (p_int_clr) else $error("interrupt kept after read");
  a_rd_zero: assert property (p_rd_zero) else $error("status not cleared");
  a_pme_mask: assert property (p_pme_mask) else $error("masked event line low");
  a_pme_clr: assert property (p_pme_clr) else $error("event line kept after read");
  c_rd_st: cover property (rd_st);
  c_int: cover property (!int_line_low_o);
  c_pme: cover property (!wake_event_line_low_o);
endmodule

// ---- wake_event_detect_and_irq_tb_top.sv ----
// testbench top for the wake event block
`timescale 1ns/1ps
module wake_event_detect_and_irq_tb_top;
  logic       mclk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       reg_wr_i, reg_rd_i, int_line_low_o, wake_event_line_low_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [1:0] port_sel_i = 2'h0, rx_port_i = 2'h0;
  logic [3:0] energy_pin_i = 4'h0, link_up_pin_i = 4'h0, int_cond_i = 4'h0;
  logic       rx_sof_i = 1'b0, rx_vld_i = 1'b0, rx_eof_i = 1'b0;
  logic       rx_to_node_i = 1'b0, rx_bcast_i = 1'b0;
  logic [7:0] rx_byte_i = 8'h00;
  logic [4:0] cases [5] = '{5'h09, 5'h05, 5'h15, 5'h01, 5'h06};
  int         miscompares = 0;
  int         cmp_count = 0;
  always #10 mclk_i = ~mclk_i;
  wake_event_detect_and_irq u_wake_event_detect_and_irq (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .port_sel_i(port_sel_i), .energy_pin_i(energy_pin_i), .link_up_pin_i(link_up_pin_i),
    .rx_port_i(rx_port_i), .rx_sof_i(rx_sof_i), .rx_vld_i(rx_vld_i), .rx_byte_i(rx_byte_i),
    .rx_eof_i(rx_eof_i), .rx_to_node_i(rx_to_node_i), .rx_bcast_i(rx_bcast_i),
    .int_cond_i(int_cond_i), .int_line_low_o(int_line_low_o),
    .wake_event_line_low_o(wake_event_line_low_o));
  wake_host_model u_wake_host_model (
    .mclk_i(mclk_i), .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_wake_host_model.rd(a, v);
    chk(v, exp);
  endtask
  task automatic pulse(input logic [3:0] c);
    @(negedge mclk_i);
    int_cond_i = c;
    @(negedge mclk_i);
    int_cond_i = 4'h0;
    repeat (2) @(negedge mclk_i);
  endtask
  // gapped byte strobes; idle data is inverted to hide stale bytes
  task automatic put(input logic [7:0] b);
    @(negedge mclk_i);
    rx_byte_i = b;
    rx_vld_i = 1'b1;
    @(negedge mclk_i);
    rx_vld_i = 1'b0;
    rx_byte_i = ~b;
  endtask
  // a lone 0xFF and junk first, so the real sync sits off the start
  task automatic frame(input logic [1:0] p, input logic tn, input logic bc, input int n);
    rx_port_i = p;
    rx_to_node_i = tn;
    rx_bcast_i = bc;
    rx_sof_i = 1'b1;
    @(negedge mclk_i);
    rx_sof_i = 1'b0;
    put(8'hFF);
    put(8'h3C);
    for (int i = 0; i < 6; i++)
      put(8'hFF);
    for (int i = 0; i < n * 6; i++)
      put(8'(17 * (i % 6 + 1)));
    @(negedge mclk_i);
    rx_eof_i = 1'b1;
    @(negedge mclk_i);
    rx_eof_i = 1'b0;
  endtask
  task automatic conclude();
    $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // run-length guard, far above the expected 1300 or so cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    chk(8'h00, 8'h01);
    conclude();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_b_i = 1'b1;
    chk({6'h00, int_line_low_o, wake_event_line_low_o}, 8'h03);
    u_wake_host_model.wr(8'h7D, 8'h1F);
    rdchk(8'h7D, 8'h1F);
    u_wake_host_model.wr(8'h10, 8'hA5);
    rdchk(8'h10, 8'h00);
    for (int k = 0; k < 4; k++) begin
      pulse(4'(1 << k));
      chk({7'h00, int_line_low_o}, 8'h00);
      rdchk(8'h7C, 8'(1 << k));
      rdchk(8'h7C, 8'h00);
      chk({7'h00, int_line_low_o}, 8'h01);
    end
    u_wake_host_model.wr(8'h7D, 8'h00);
    pulse(4'hF);
    chk({6'h00, int_line_low_o, wake_event_line_low_o}, 8'h03);
    rdchk(8'h7C, 8'h0F);
    u_wake_host_model.wr(8'h7D, 8'h1F);
    for (int i = 0; i < 6; i++)
      u_wake_host_model.wr(8'(8'h81 + i), 8'(17 * (i + 1)));
    port_sel_i = 2'h1;
    u_wake_host_model.wr(8'h7E, 8'h07);
    port_sel_i = 2'h2;
    u_wake_host_model.wr(8'h7E, 8'h00);
    // only port 1 scans; own or broadcast with all sixteen copies wakes
    for (int c = 0; c < 5; c++) begin
      logic hit;
      hit = !cases[c][4] && (cases[c][2] || cases[c][3]) && cases[c][1:0] == 2'h1;
      frame(cases[c][1:0], cases[c][2], cases[c][3], cases[c][4] ? 15 : 16);
      repeat (3) @(negedge mclk_i);
      chk({7'h00, wake_event_line_low_o}, {7'h00, !hit});
      port_sel_i = cases[c][1:0];
      rdchk(8'h7F, {5'h00, hit, 2'h0});
      rdchk(8'h7C, {3'h0, hit, 4'h0});
      // the line is a register fed by the status, so it rises one edge after the clear
      @(negedge mclk_i);
      chk({7'h00, wake_event_line_low_o}, 8'h01);
    end
    port_sel_i = 2'h0;
    u_wake_host_model.wr(8'h7E, 8'h03);
    u_wake_host_model.wr(8'h80, 8'h10);
    energy_pin_i = 4'h1;
    repeat (8) @(negedge mclk_i);
    energy_pin_i = 4'h0;
    repeat (30) @(negedge mclk_i);
    rdchk(8'h7F, 8'h00);
    energy_pin_i = 4'h1;
    repeat (40) @(negedge mclk_i);
    rdchk(8'h7F, 8'h01);
    rdchk(8'h7C, 8'h10);
    energy_pin_i = 4'h0;
    link_up_pin_i = 4'h1;
    repeat (10) @(negedge mclk_i);
    rdchk(8'h7F, 8'h02);
    rdchk(8'h7C, 8'h10);
    conclude();
  end
endmodule
bind wake_event_detect_and_irq wake_event_detect_and_irq_props u_props (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .energy_pin_i(energy_pin_i), .link_up_pin_i(link_up_pin_i), .rx_eof_i(rx_eof_i),
  .int_cond_i(int_cond_i), .int_line_low_o(int_line_low_o),
  .wake_event_line_low_o(wake_event_line_low_o));

// ---- wake_host_model.sv ----
// host model driving the register port after falling edges
`timescale 1ns/1ps
module wake_host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o
);
  // idle bus shows inverted last values so nothing stale matches
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // one-cycle write strobe; all registers reached only this way
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge mclk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  // data is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge mclk_i);
    d = reg_rdata_i;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
  endtask
endmodule

// ---- wake_pkg.sv ----
// types shared by the wake event block
package wake_pkg;
  typedef enum logic [1:0] {
    SCAN_SYNC  = 2'b00,
    SCAN_ADDR  = 2'b01,
    SCAN_DONE  = 2'b10
  } scan_state_t;
endpackage

// ---- wake_scanner.sv ----
// one-port wake packet scanner over a received payload byte stream
`timescale 1ns/1ps
`include "wake_consts.svh"
module wake_scanner
  import wake_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        enable_i,
  input  wire logic        sof_i,
  input  wire logic        byte_vld_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic        eof_i,
  input  wire logic [47:0] mac_i,
  output logic             match_o
);
  scan_state_t state_q;
  scan_state_t state_d;
  logic [2:0]  sync_cnt_q;
  logic [2:0]  sync_cnt_d;
  logic [6:0]  addr_cnt_q;
  logic [6:0]  addr_cnt_d;
  logic [2:0]  byte_idx;
  logic [7:0]  want_byte;
  logic        is_ff;
  logic        is_want;
  logic        last_addr;

  // address bytes go out msb first, as on the wire
  assign byte_idx  = 3'(addr_cnt_q % 7'd6);
  assign want_byte = mac_i[8'(47 - 8 * byte_idx) -: 8];
  assign is_ff     = byte_i == `SYNC_BYTE;
  assign is_want   = byte_i == want_byte;
  assign last_addr = addr_cnt_q == 7'(`ADDR_REPEATS * `MAC_BYTES - 1);

  // a break in the address run falls back to sync hunting, so any offset works
  always_comb begin
    state_d    = state_q;
    sync_cnt_d = sync_cnt_q;
    addr_cnt_d = addr_cnt_q;
    if (sof_i || !enable_i) begin
      state_d    = SCAN_SYNC;
      sync_cnt_d = 3'h0;
      addr_cnt_d = 7'h00;
    end else if (byte_vld_i) begin
      unique case (state_q)
        SCAN_SYNC: begin
          if (is_ff) begin
            if (sync_cnt_q == 3'(`SYNC_LEN - 1)) begin
              state_d    = SCAN_ADDR;
              addr_cnt_d = 7'h00;
            end else begin
              sync_cnt_d = sync_cnt_q + 3'h1;
            end
          end else begin
            sync_cnt_d = 3'h0;
          end
        end
        SCAN_ADDR: begin
          if (is_want) begin
            addr_cnt_d = addr_cnt_q + 7'h01;
            if (last_addr) begin
              state_d = SCAN_DONE;
            end
          end else if (is_ff) begin
            // long ff runs keep the sync satisfied
            if (addr_cnt_q != 7'h00) begin
              state_d    = SCAN_SYNC;
              sync_cnt_d = 3'h1;
            end
          end else begin
            state_d    = SCAN_SYNC;
            sync_cnt_d = 3'h0;
          end
        end
        SCAN_DONE: begin
          state_d = SCAN_DONE;
        end
        default: begin
          state_d = SCAN_SYNC;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q    <= SCAN_SYNC;
      sync_cnt_q <= 3'h0;
      addr_cnt_q <= 7'h00;
    end else begin
      state_q    <= state_d;
      sync_cnt_q <= sync_cnt_d;
      addr_cnt_q <= addr_cnt_d;
    end
  end

  // a frame without the full sequence yields nothing
  assign match_o = eof_i && enable_i && state_q == SCAN_DONE;
endmodule
